// ==== bench/ccm_core_model.sv ====
/*
  Core side model: makes the four-phase strobes and the clock enable.
  Assumes the block samples strobes on the rising clock edge.
*/
`timescale 1ns/1ns
`default_nettype none
module ccm_core_model (
  input  wire logic       core_clk_i,
  input  wire logic       nrst_i,
  output logic            ce_o,
  output logic [3:0]      phase_o
);
  // One-hot phase rotation, changed away from the sampling edge
  always @(negedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      phase_o <= 4'h1;
    end else begin
      phase_o <= {phase_o[2:0], phase_o[3]};
    end
  end
  assign ce_o = 1'b1;
endmodule
`default_nettype wire

// ==== bench/ccm_properties.sv ====
/*
  Checker for the dual comparator control block, bound to ccm_top.
  Assumes ce_i stays high and the phase strobes rotate every cycle.
*/
`timescale 1ns/1ns
`default_nettype none
module ccm_properties
  import ccm_pkg::*;
#(
  parameter int unsigned N = CCM_NUM
)
(
  input wire logic         core_clk_i,
  input wire logic         nrst_i,
  input wire logic [N-1:0] ctrl_wr_i,
  input wire logic [N-1:0] port_direction_bit_i,
  input wire logic [N-1:0] flag_wr_i,
  input wire logic [N-1:0] flag_wdata_i,
  input wire logic [N-1:0] cmp_int_enable_i,
  input wire logic         peripheral_int_enable_i,
  input wire logic         global_int_enable_i,
  input wire logic [7:0]   cmp_one_control_reg_o,
  input wire logic [7:0]   cmp_shared_control_reg_o,
  input wire logic [N-1:0] pin_oe_o,
  input wire logic [N-1:0] cmp_int_flag_o,
  input wire logic         irq_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!nrst_i);

  // Pin drive, output value, interrupt flag and request, and speed bit relations
  property p_oe_dir;
    port_direction_bit_i[0] [*3] |-> !pin_oe_o[0];
  endproperty
  a_oe_dir: assert property (p_oe_dir) else $error("pin driven as input");
  property p_off_pol0;
    (!cmp_one_control_reg_o[7] && !cmp_one_control_reg_o[4]) [*8]
      |-> !cmp_one_control_reg_o[6];
  endproperty
  a_off_pol0: assert property (p_off_pol0) else $error("off out not 0");
  property p_off_pol1;
    (!cmp_one_control_reg_o[7] && cmp_one_control_reg_o[4]) [*8]
      |-> cmp_one_control_reg_o[6];
  endproperty
  a_off_pol1: assert property (p_off_pol1) else $error("off out not 1");
  property p_mirror;
    $stable(cmp_one_control_reg_o[6]) [*3]
      |-> cmp_shared_control_reg_o[7] == cmp_one_control_reg_o[6];
  endproperty
  a_mirror: assert property (p_mirror) else $error("mirror differs");
  property p_irq_gie;
    !global_int_enable_i [*3] |-> !irq_o;
  endproperty
  a_irq_gie: assert property (p_irq_gie) else $error("irq while masked");
  property p_irq_on;
    (cmp_int_flag_o[0] && cmp_int_enable_i[0] && peripheral_int_enable_i
      && global_int_enable_i) [*3] |-> irq_o;
  endproperty
  a_irq_on: assert property (p_irq_on) else $error("irq missing");
  property p_flag_set;
    flag_wr_i[0] && flag_wdata_i[0] |-> ##[1:2] cmp_int_flag_o[0];
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("flag not set");
  property p_sp_fall;
    $fell(cmp_one_control_reg_o[3])
      |-> $past(ctrl_wr_i[0], 2) || $past(ctrl_wr_i[0], 1);
  endproperty
  a_sp_fall: assert property (p_sp_fall) else $error("speed bit fell");

  // Main scenarios reached
  c_irq: cover property (irq_o);
  c_flag: cover property ($rose(cmp_int_flag_o[0]));
  c_pin: cover property (pin_oe_o[0]);
endmodule

bind ccm_top ccm_properties #(.N(N)) u_props (.*);
`default_nettype wire

// ==== bench/test_ccm_top.sv ====
/*
  Self-checking bench for ccm_top: control writes, output, mismatch flag.
  Assumes the core model supplies phases; inputs change at falling edges.
*/
`timescale 1ns/1ns
`default_nettype none
module test_ccm_top;
  import ccm_pkg::*;
  logic       core_clk_i, nrst_i, ce_i, pie, gie;
  logic [3:0] phase_i;
  logic [1:0] raw, rd, wr, dir, fwr, fwd, ie, pin_out, pin_oe, flag, tg;
  ccm_ctrl_t  wd;
  ccm_ana_t [1:0] ana;
  logic [7:0] img1, img2, shr;
  logic       irq_o, shwr, tclk, wake;
  logic [1:0] pdat;
  logic [7:0] shwd;
  int         err_count, samples_checked;

  ccm_core_model u_core (.core_clk_i(core_clk_i), .nrst_i(nrst_i),
    .ce_o(ce_i), .phase_o(phase_i));
  ccm_top dut (.core_clk_i(core_clk_i), .nrst_i(nrst_i), .ce_i(ce_i),
    .phase_i(phase_i), .sleep_i(1'b0), .raw_cmp_i(raw), .ctrl_rd_i(rd),
    .ctrl_wr_i(wr), .ctrl_wdata_i(wd), .shared_wr_i(shwr),
    .shared_wdata_i(shwd), .port_direction_bit_i(dir),
    .port_data_i(pdat), .flag_wr_i(fwr), .flag_wdata_i(fwd),
    .cmp_int_enable_i(ie), .peripheral_int_enable_i(pie),
    .global_int_enable_i(gie), .timer_clk_i(tclk),
    .cmp_one_control_reg_o(img1), .cmp_two_control_reg_o(img2),
    .cmp_shared_control_reg_o(shr), .ana_ctrl_o(ana), .pin_out_o(pin_out),
    .pin_oe_o(pin_oe), .cmp_int_flag_o(flag), .irq_o(irq_o), .wake_o(wake),
    .timer_gate_o(tg));

  // Clock and watchdog
  initial begin
    core_clk_i = 1'b0;
    forever #25 core_clk_i = ~core_clk_i;
  end
  initial begin
    repeat (3000) @(posedge core_clk_i);
    err_count++;
    finish_test();
  end

  task automatic finish_test();
    if (err_count == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic settle();
    repeat (12) @(negedge core_clk_i);
  endtask
  // One-cycle strobes: control write or read, flag write, shared write; raw level set and held
  task automatic wr_ctrl(input ccm_ctrl_t d);
    @(negedge core_clk_i);
    wd = d;
    wr = 2'h1;
    @(negedge core_clk_i);
    wr = 2'h0;
    settle();
  endtask
  task automatic rd_ctrl();
    @(negedge core_clk_i);
    rd = 2'h1;
    @(negedge core_clk_i);
    rd = 2'h0;
    settle();
  endtask
  task automatic wr_flag(input logic v);
    @(negedge core_clk_i);
    fwd = {1'b0, v};
    fwr = 2'h1;
    @(negedge core_clk_i);
    fwr = 2'h0;
    settle();
  endtask
  task automatic wr_shared(input logic [7:0] v);
    @(negedge core_clk_i);
    shwd = v;
    shwr = 1'b1;
    @(negedge core_clk_i);
    shwr = 1'b0;
    settle();
  endtask
  task automatic set_raw(input logic v);
    @(negedge core_clk_i);
    raw = {1'b0, v};
    settle();
  endtask

  initial begin
    nrst_i = 1'b0; raw = '0; rd = '0; wr = '0; dir = '0; fwr = '0;
    fwd = '0; ie = '0; pie = 1'b0; gie = 1'b0; wd = '0;
    shwr = 1'b0; shwd = '0; tclk = 1'b0; pdat = '0;
    err_count = 0; samples_checked = 0;
    repeat (5) @(negedge core_clk_i);
    nrst_i = 1'b1;
    settle();
    chk(img1, 8'h08);
    chk(img2, 8'h08);
    chk(shr, 8'h00);
    // Every input code, reference toggled alongside
    for (int c = 0; c < 4; c++) begin
      wr_ctrl('{1'b1, 1'b0, 1'b0, 1'b1, c[0], c[1:0]});
      chk(img1, 8'h88 | 8'(c[0]) << 2 | 8'(c));
      chk(8'(ana[0].neg_pin_onehot), 8'h01 << c);
      chk(8'({ana[0].pos_from_ref, ana[0].power_on}), 8'(c[0]) << 1 | 8'h1);
    end
    wr_ctrl('{1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 2'h0});
    wr_flag(1'b0);
    set_raw(1'b1);
    chk(img1, 8'hE8);
    chk(shr, 8'h80);
    chk(8'({pin_oe[0], pin_out[0]}), 8'h03);
    chk(8'(flag[0]), 8'h01);
    wr_flag(1'b0);
    chk(8'(flag[0]), 8'h00);
    rd_ctrl();
    set_raw(1'b0);
    chk(8'(flag[0]), 8'h01);
    // Interrupt request masking, flag set by software
    ie = 2'h1; pie = 1'b1; gie = 1'b1;
    wr_flag(1'b0);
    chk(8'({flag[0], irq_o}), 8'h00);
    wr_flag(1'b1);
    chk(8'({flag[0], irq_o}), 8'h03);
    gie = 1'b0;
    settle();
    chk(8'({flag[0], irq_o}), 8'h02);
    chk(8'(wake), 8'h01);
    // Write refresh with pin output off
    wr_ctrl('{1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 2'h0});
    pdat = 2'h1;
    settle();
    chk(8'(pin_out[0]), 8'h01);
    set_raw(1'b1);
    wr_flag(1'b0);
    wr_ctrl('{1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 2'h0});
    set_raw(1'b0);
    chk(8'(flag[0]), 8'h01);
    wr_ctrl('{1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 2'h0});
    chk(img1, 8'hF8);
    dir = 2'h1;
    settle();
    chk(8'(pin_oe[0]), 8'h00);
    wr_ctrl('{1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 2'h0});
    chk(img1, 8'h70);
    chk(8'({ana[0].power_on, ana[0].speed_normal}), 8'h00);
    // Timer gate: free running, then held until timer clock falls
    chk(8'(tg[0]), 8'h01);
    wr_shared(8'h22);
    chk(shr, 8'hA2);
    chk(8'(ana[0].ref_from_dac), 8'h01);
    wr_ctrl('{1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 2'h0});
    chk(8'(tg[0]), 8'h01);
    tclk = 1'b1;
    settle();
    tclk = 1'b0;
    settle();
    chk(8'(tg[0]), 8'h00);
    finish_test();
  end
endmodule
`default_nettype wire

// ==== src/ccm_pkg.sv ====
/*
  Package for the dual comparator control and mismatch interrupt block:
  control field layout, reset values and the carrier structs.
  Assumes a four-phase instruction clock delivered as phase strobes.
*/
// Functional notes
// R1: Raw result high when plus exceeds minus
// R2: Disabled comparator feeds zero to XOR
// R3: Enable bit powers comparator up or down
// R4: Two-bit field picks inverting input pin
// R5: Codes 00..11 select negative pins 0..3
// R6: Reference bit picks plus input source
// R7: One selects internal reference, zero pin
// R8: Output bit and mirror show output
// R9: Pin driven when enable, direction, on; code ignores on for drive, driving low when off
// R10: Output enable overrides port data latch
// R11: Internal output latched each instruction cycle
// R12: Polarity bit inverts the comparator output
// R13: Speed bit resets to one, normal
// R14: First latch captures on access phase three
// R15: First latch holds until access or reset
// R16: Second latch captures every phase one
// R17: Latch XOR flags mismatch until refreshed
// R18: Writes also refresh first latch
// R19: Detection independent of pin output enable
// R20: Flag set on mismatch rising edge
// R21: Software clears flag by zero, sets by one
// R22: Request needs flag and three enables
// R23: Phase one held high during sleep
// R24: Sync bit latches timer output on fall
// R25: Reset returns control registers to defaults
// R26: Phases as strobes, latches as gated flops
package ccm_pkg;

  localparam int unsigned CCM_NUM = 2;

  // Control register bit positions
  localparam int unsigned CCM_BIT_ON  = 7;
  localparam int unsigned CCM_BIT_OUT = 6;
  localparam int unsigned CCM_BIT_OE  = 5;
  localparam int unsigned CCM_BIT_POL = 4;
  localparam int unsigned CCM_BIT_SP  = 3;
  localparam int unsigned CCM_BIT_REF = 2;
  localparam int unsigned CCM_BIT_CH  = 0;

  // Control register reset value: only speed bit set
  localparam logic [7:0] CCM_CTRL_RST = 8'h08;

  // Shared register bit positions
  localparam int unsigned CCM_SH_MIR1 = 7;
  localparam int unsigned CCM_SH_MIR2 = 6;
  localparam int unsigned CCM_SH_RSEL1 = 5;
  localparam int unsigned CCM_SH_RSEL2 = 4;
  localparam int unsigned CCM_SH_HYS1 = 3;
  localparam int unsigned CCM_SH_HYS2 = 2;
  localparam int unsigned CCM_SH_SYNC1 = 1;
  localparam int unsigned CCM_SH_SYNC2 = 0;
  localparam logic [7:0] CCM_SHARED_RST = 8'h00;

  // Per-comparator control fields
  typedef struct packed {
    logic       cmp_enable_bit;
    logic       cmp_pin_output_enable;
    logic       cmp_invert_select;
    logic       cmp_speed_select;
    logic       cmp_ref_select;
    logic [1:0] cmp_neg_input_select;
  } ccm_ctrl_t;

  // Analog front-end controls for one comparator
  typedef struct packed {
    logic       power_on;
    logic       speed_normal;
    logic       pos_from_ref;
    logic [3:0] neg_pin_onehot;
    logic       ref_from_dac;
    logic       hyst_on;
  } ccm_ana_t;

endpackage

// ==== src/ccm_top.sv ====
/*
  Dual comparator control with mismatch interrupt logic.
  Analog comparators sit outside; their raw results arrive as pins and
  are synchronised here. Control bits arrive as plain ports with write
  strobes from the core, which runs a four-phase instruction cycle.
*/
`timescale 1ns/1ns
`default_nettype none
module ccm_top
  import ccm_pkg::*;
#(
  parameter int unsigned N = CCM_NUM
)
(
  input  wire logic            core_clk_i,
  input  wire logic            nrst_i,
  input  wire logic            ce_i,
  input  wire logic [3:0]      phase_i,
  input  wire logic            sleep_i,
  input  wire logic [N-1:0]    raw_cmp_i,
  input  wire logic [N-1:0]    ctrl_rd_i,
  input  wire logic [N-1:0]    ctrl_wr_i,
  input  wire ccm_ctrl_t       ctrl_wdata_i,
  input  wire logic            shared_wr_i,
  input  wire logic [7:0]      shared_wdata_i,
  input  wire logic [N-1:0]    port_direction_bit_i,
  input  wire logic [N-1:0]    port_data_i,
  input  wire logic [N-1:0]    flag_wr_i,
  input  wire logic [N-1:0]    flag_wdata_i,
  input  wire logic [N-1:0]    cmp_int_enable_i,
  input  wire logic            peripheral_int_enable_i,
  input  wire logic            global_int_enable_i,
  input  wire logic            timer_clk_i,
  output logic [7:0]           cmp_one_control_reg_o,
  output logic [7:0]           cmp_two_control_reg_o,
  output logic [7:0]           cmp_shared_control_reg_o,
  output ccm_ana_t [N-1:0]     ana_ctrl_o,
  output logic [N-1:0]         pin_out_o,
  output logic [N-1:0]         pin_oe_o,
  output logic [N-1:0]         cmp_int_flag_o,
  output logic                 irq_o,
  output logic                 wake_o,
  output logic [N-1:0]         timer_gate_o
);

  // Whole block state
  typedef struct packed {
    ccm_ctrl_t [N-1:0] ctrl;
    logic [7:0]        shared;
    logic [N-1:0]      s1;
    logic [N-1:0]      s2;
    logic [N-1:0]      s3;
    logic [N-1:0]      raw;
    logic [2:0]        tck;
    logic [N-1:0]      mm_q;
    logic [N-1:0]      flag;
    logic [N-1:0]      tsync;
    logic [N-1:0]      pin;
    logic [N-1:0]      oe;
    logic              irq;
    logic              wake;
    ccm_ana_t [N-1:0]  ana;
    logic [7:0]        rd1;
    logic [7:0]        rd2;
    logic [7:0]        rdsh;
  } ccm_st_t;

  ccm_st_t       st_q;
  ccm_st_t       st_d;
  logic [N-1:0]  out_comb;
  logic [N-1:0]  out_q;
  logic [N-1:0]  mism;
  logic [N-1:0]  access;
  logic          ph1;
  logic          ph3;
  logic          tfall;

  // Phase strobes from the instruction cycle
  assign ph1 = phase_i[0];                               // R26
  assign ph3 = phase_i[2];                               // R26
  // Reads and writes both count as accesses
  assign access = ctrl_rd_i | ctrl_wr_i;                 // R18
  // Falling edge of timer clock, filtered sample agrees
  assign tfall = (st_q.tck[2] == st_q.tck[1]) && st_q.tck[2]
                 && !st_q.tck[1] ? 1'b0 :
                 (st_q.tck[1] == st_q.tck[0]) && st_q.tck[2]
                 && !st_q.tck[1];

  // One channel per comparator
  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_unit
      ccm_unit u_unit (
        .core_clk_i (core_clk_i),
        .nrst_i     (nrst_i),
        .ce_i       (ce_i),
        .raw_i      (st_q.raw[g]),
        .on_i       (st_q.ctrl[g].cmp_enable_bit),
        .pol_i      (st_q.ctrl[g].cmp_invert_select),
        .ph1_i      (ph1),
        .ph3_i      (ph3),
        .access_i   (access[g]),
        .sleep_i    (sleep_i),
        .out_comb_o (out_comb[g]),
        .out_q_o    (out_q[g]),
        .mismatch_o (mism[g])
      );
    end
  endgenerate

  // Pack a control register image for reads
  function automatic logic [7:0] ctrl_img(input ccm_ctrl_t c,
                                          input logic o);
    logic [7:0] r;
    r = 8'h00;
    r[CCM_BIT_ON]  = c.cmp_enable_bit;
    r[CCM_BIT_OUT] = o;                                  // R8
    r[CCM_BIT_OE]  = c.cmp_pin_output_enable;
    r[CCM_BIT_POL] = c.cmp_invert_select;
    r[CCM_BIT_SP]  = c.cmp_speed_select;
    r[CCM_BIT_REF] = c.cmp_ref_select;
    r[CCM_BIT_CH+:2] = c.cmp_neg_input_select;
    return r;
  endfunction

  // Next-state logic for the whole block
  always_comb begin
    st_d = st_q;
    // Three-stage synchroniser; change taken when stages 2 and 3 agree
    st_d.s1 = raw_cmp_i;
    st_d.s2 = st_q.s1;
    st_d.s3 = st_q.s2;
    for (int i = 0; i < N; i++) begin
      if (st_q.s2[i] == st_q.s3[i]) begin
        st_d.raw[i] = st_q.s3[i];                        // R1
      end
    end
    st_d.tck = {st_q.tck[1:0], timer_clk_i};
    for (int i = 0; i < N; i++) begin
      // Control writes land in the cycle after the write strobe, whatever the phase
      if (ctrl_wr_i[i]) begin
        st_d.ctrl[i] = ctrl_wdata_i;                     // R3 R13
      end
      // Interrupt flag: rising mismatch edge wins over clear
      st_d.mm_q[i] = mism[i];
      if (flag_wr_i[i]) begin
        st_d.flag[i] = flag_wdata_i[i];                  // R21
      end
      if (mism[i] && !st_q.mm_q[i]) begin
        st_d.flag[i] = 1'b1;                             // R20 R19
      end
      // Pin drive: output enable overrides port latch
      st_d.oe[i] = st_q.ctrl[i].cmp_pin_output_enable
                   && !port_direction_bit_i[i];          // R9
      st_d.pin[i] = st_q.ctrl[i].cmp_pin_output_enable
                    ? (out_comb[i] && st_q.ctrl[i].cmp_enable_bit)
                    : port_data_i[i];                    // R10 R9
      // Timer gate: follows output, or waits for timer fall if synced
      if (tfall || !((i == 0) ? st_q.shared[CCM_SH_SYNC1]
                               : st_q.shared[CCM_SH_SYNC2])) begin
        st_d.tsync[i] = out_q[i];                        // R24
      end
      // Analog controls
      st_d.ana[i].power_on     = st_q.ctrl[i].cmp_enable_bit;   // R3
      st_d.ana[i].speed_normal = st_q.ctrl[i].cmp_speed_select; // R13
      st_d.ana[i].pos_from_ref = st_q.ctrl[i].cmp_ref_select;   // R6 R7
      st_d.ana[i].neg_pin_onehot =
        4'h1 << st_q.ctrl[i].cmp_neg_input_select;       // R4 R5
    end
    st_d.ana[0].ref_from_dac = st_q.shared[CCM_SH_RSEL1];
    st_d.ana[0].hyst_on      = st_q.shared[CCM_SH_HYS1];
    if (N > 1) begin
      st_d.ana[N-1].ref_from_dac = st_q.shared[CCM_SH_RSEL2];
      st_d.ana[N-1].hyst_on      = st_q.shared[CCM_SH_HYS2];
    end
    if (shared_wr_i) begin
      st_d.shared = shared_wdata_i;
    end
    st_d.shared[CCM_SH_MIR1] = 1'b0;
    st_d.shared[CCM_SH_MIR2] = 1'b0;
    // Interrupt request and sleep wake
    st_d.irq  = |(st_q.flag & cmp_int_enable_i)
                && peripheral_int_enable_i
                && global_int_enable_i;                  // R22
    st_d.wake = |(st_q.flag & cmp_int_enable_i)
                && peripheral_int_enable_i;
    // Read images with mirrored outputs
    st_d.rd1 = ctrl_img(st_q.ctrl[0], out_q[0]);
    st_d.rd2 = ctrl_img(st_q.ctrl[N-1], out_q[N-1]);
    st_d.rdsh = st_q.shared;
    st_d.rdsh[CCM_SH_MIR1] = out_q[0];                   // R8
    st_d.rdsh[CCM_SH_MIR2] = out_q[N-1];
  end

  // State register
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st_q <= '0;
      for (int i = 0; i < N; i++) begin
        st_q.ctrl[i] <= CCM_CTRL_RST[6:0];               // R25
      end
      st_q.shared <= CCM_SHARED_RST;                     // R25
    end else if (ce_i) begin
      st_q <= st_d;
    end
  end

  // Outputs straight from flops
  assign cmp_one_control_reg_o    = st_q.rd1;
  assign cmp_two_control_reg_o    = st_q.rd2;
  assign cmp_shared_control_reg_o = st_q.rdsh;
  assign ana_ctrl_o               = st_q.ana;
  assign pin_out_o                = st_q.pin;
  assign pin_oe_o                 = st_q.oe;
  assign cmp_int_flag_o           = st_q.flag;
  assign irq_o                    = st_q.irq;
  assign wake_o                   = st_q.wake;
  assign timer_gate_o             = st_q.tsync;

endmodule
`default_nettype wire

// ==== src/ccm_unit.sv ====
/*
  One comparator channel: polarity, sampled output and mismatch latches.
  Assumes phase strobes and access strobes synchronous to core_clk_i.
*/
`timescale 1ns/1ns
`default_nettype none
module ccm_unit
  import ccm_pkg::*;
(
  input  wire logic core_clk_i,
  input  wire logic nrst_i,
  input  wire logic ce_i,
  input  wire logic raw_i,
  input  wire logic on_i,
  input  wire logic pol_i,
  input  wire logic ph1_i,
  input  wire logic ph3_i,
  input  wire logic access_i,
  input  wire logic sleep_i,
  output logic      out_comb_o,
  output logic      out_q_o,
  output logic      mismatch_o
);

  typedef struct packed {
    logic l1;
    logic l2;
    logic out;
    logic acc;
  } ccm_unit_st_t;

  ccm_unit_st_t st_q;
  ccm_unit_st_t st_d;
  logic         gated;

  // Gate by enable, then polarity XOR
  assign gated      = raw_i & on_i;        // R2
  assign out_comb_o = gated ^ pol_i;       // R12
  assign out_q_o    = st_q.out;
  assign mismatch_o = st_q.l1 ^ st_q.l2;   // R17

  // Latch updates on phase strobes
  always_comb begin
    st_d = st_q;
    if (access_i) begin
      st_d.acc = 1'b1;
    end
    if (ph3_i && (st_q.acc || access_i)) begin
      st_d.l1  = out_comb_o;               // R14 R18
      st_d.acc = 1'b0;
    end
    if (ph1_i || sleep_i) begin
      st_d.l2  = out_comb_o;               // R16 R23
      st_d.out = out_comb_o;               // R11
    end
  end

  // State register, held by clock enable
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st_q <= '0;                          // R15
    end else if (ce_i) begin
      st_q <= st_d;
    end
  end

endmodule
`default_nettype wire
